// [include/wdt_pkg.sv]
// Package for the dual-stage watchdog: register map, fields, actions, timing.
// Assumes a 50 MHz hclk and an AHB-Lite register bus with 32-bit data.
package wdt_pkg;
	localparam logic [7:0]  ctrl_addr      = 8'h00;
	localparam logic [7:0]  stage1_addr    = 8'h04;
	localparam logic [7:0]  stage2_addr    = 8'h08;
	localparam logic [7:0]  trigger_addr   = 8'h0C;
	localparam logic [7:0]  status_addr    = 8'h10;
	localparam logic [7:0]  count_addr     = 8'h14;
	localparam int          ctrl_en_bit    = 0;
	localparam int          ctrl_ind_bit   = 1;
	localparam int          ctrl_act1_lsb  = 4;
	localparam int          ctrl_act2_lsb  = 8;
	localparam int          stat_stage_lsb = 0;
	localparam int          stat_tout_bit  = 2;
	localparam int          stat_ind_bit   = 3;
	localparam logic [31:0] stage_reset    = 32'h02FA_F080;
	localparam logic [31:0] ctrl_reset     = 32'h0000_0000;
	localparam int          pulse_ns       = 1000;
	localparam int          clk_ns         = 20;
	localparam logic [7:0]  pulse_cycles   = 8'((pulse_ns + clk_ns - 1) / clk_ns);
	typedef enum logic [2:0] {
		act_none, act_reset, act_nmi, act_smi, act_sci, act_delay
	} action_e;
	typedef enum logic [1:0] {st_idle, st_one, st_two, st_done} stage_e;
endpackage : wdt_pkg

// [rtl/dual_stage_watchdog.sv]
// Dual-stage watchdog with AHB-Lite register slave and board-level pins.
// Assumes one 50 MHz clock; keep-alive strobe arrives asynchronously from the carrier.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module dual_stage_watchdog
	import wdt_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        keepalive_strobe_n,
	output logic             timeout_indicator_out,
	output logic             module_reset,
	output logic             nmi_irq,
	output logic             sys_mgmt_irq,
	output logic             sys_control_irq
);
	logic        en;
	logic        ind_en;
	logic [2:0]  act1;
	logic [2:0]  act2;
	logic [31:0] period1;
	logic [31:0] period2;
	logic [31:0] count;
	logic        tout_seen;
	stage_e      stage;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        strobe_sync;
	logic        strobe_prev;
	logic        reset_pulse;
	logic        nmi_pulse;
	logic        smi_pulse;
	logic        sci_pulse;

	// Bus decode
	wire         bus_take   = hsel && hready && htrans[1];
	wire         rd_take    = bus_take && !hwrite;
	wire         wr_take    = bus_take && hwrite;
	wire [7:0]   addr_lo    = haddr[7:0];
	wire         wr_ctrl    = wr_pend && (wr_addr == ctrl_addr);
	wire         wr_p1      = wr_pend && (wr_addr == stage1_addr);
	wire         wr_p2      = wr_pend && (wr_addr == stage2_addr);
	wire         wr_trig    = wr_pend && (wr_addr == trigger_addr);
	wire         wr_stat    = wr_pend && (wr_addr == status_addr);

	// Service events
	wire         strobe_ev  = strobe_prev && !strobe_sync;
	wire         service    = strobe_ev || wr_trig;
	wire         new_en     = wr_ctrl ? hwdata[ctrl_en_bit] : en;

	// Stage expiry
	wire         count_done = (count == 32'h0000_0001);
	wire [2:0]   cur_act    = (stage == st_two) ? act2 : act1;
	wire         skip1      = (act1 == act_none);
	wire         skip2      = (act2 == act_none);
	wire         expire     = count_done && ((stage == st_one) || (stage == st_two));
	wire         fire_rst   = expire && (cur_act == act_reset);
	wire         fire_nmi   = expire && (cur_act == act_nmi);
	wire         fire_smi   = expire && (cur_act == act_smi);
	wire         fire_sci   = expire && (cur_act == act_sci);
	wire         tout_ev    = expire && (cur_act != act_delay);

	// Read mux
	wire [31:0]  ctrl_word  = {20'h0_0000, 1'b0, act2, 1'b0, act1, 2'b00, ind_en, en};
	wire [31:0]  stat_word  = {28'h000_0000, timeout_indicator_out, tout_seen, stage};
	wire [31:0]  rd_word    = (addr_lo == ctrl_addr)   ? ctrl_word :
	                          (addr_lo == stage1_addr) ? period1 :
	                          (addr_lo == stage2_addr) ? period2 :
	                          (addr_lo == status_addr) ? stat_word :
	                          (addr_lo == count_addr)  ? count : 32'h0000_0000;

	wdt_sync strobe_sync_i (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (keepalive_strobe_n),
		.dout    (strobe_sync)
	);

	// Action pulses stretched so slow interrupt logic sees them
	wdt_pulse rst_p (.hclk(hclk), .hresetn(hresetn), .fire(fire_rst), .pulse(reset_pulse));
	wdt_pulse nmi_p (.hclk(hclk), .hresetn(hresetn), .fire(fire_nmi), .pulse(nmi_pulse));
	wdt_pulse smi_p (.hclk(hclk), .hresetn(hresetn), .fire(fire_smi), .pulse(smi_pulse));
	wdt_pulse sci_p (.hclk(hclk), .hresetn(hresetn), .fire(fire_sci), .pulse(sci_pulse));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			module_reset    <= 1'b0;
			nmi_irq         <= 1'b0;
			sys_mgmt_irq    <= 1'b0;
			sys_control_irq <= 1'b0;
		end else begin
			module_reset    <= reset_pulse;
			nmi_irq         <= nmi_pulse;
			sys_mgmt_irq    <= smi_pulse;
			sys_control_irq <= sci_pulse;
		end
	end

	// Bus slave: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend   <= wr_take;
			wr_addr   <= addr_lo;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (rd_take) begin
				hrdata <= rd_word;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en      <= ctrl_reset[ctrl_en_bit];
			ind_en  <= ctrl_reset[ctrl_ind_bit];
			act1    <= act_none;
			act2    <= act_none;
			period1 <= stage_reset;
			period2 <= stage_reset;
		end else begin
			if (wr_ctrl) begin
				en     <= hwdata[ctrl_en_bit];
				ind_en <= hwdata[ctrl_ind_bit];
				act1   <= hwdata[ctrl_act1_lsb +: 3];
				act2   <= hwdata[ctrl_act2_lsb +: 3];
			end
			if (wr_p1) begin
				period1 <= hwdata;
			end
			if (wr_p2) begin
				period2 <= hwdata;
			end
		end
	end

	// Strobe edge history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strobe_prev <= 1'b1;
		end else begin
			strobe_prev <= strobe_sync;
		end
	end

	// Stage sequencer; a zero period lasts one cycle but fires no action
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage <= st_idle;
			count <= 32'h0000_0000;
		end else if (!new_en) begin
			stage <= st_idle;
			count <= 32'h0000_0000;
		end else if (service || (stage == st_idle)) begin
			stage <= st_one;
			count <= period1;
		end else begin
			case (stage)
				st_one: begin
					if (skip1 || count_done || count == 32'h0000_0000) begin
						stage <= skip2 ? st_done : st_two;
						count <= period2;
					end else begin
						count <= count - 32'h0000_0001;
					end
				end
				st_two: begin
					if (skip2 || count_done || count == 32'h0000_0000) begin
						stage <= st_done;
						count <= 32'h0000_0000;
					end else begin
						count <= count - 32'h0000_0001;
					end
				end
				st_done: begin
					count <= 32'h0000_0000;
				end
				default: begin
					stage <= st_idle;
				end
			endcase
		end
	end

	// Time-out flag: set wins over a software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tout_seen <= 1'b0;
		end else if (tout_ev && !(cur_act == act_none)) begin
			tout_seen <= 1'b1;
		end else if (wr_stat && hwdata[stat_tout_bit]) begin
			tout_seen <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timeout_indicator_out <= 1'b0;
		end else begin
			timeout_indicator_out <= tout_seen && ind_en;
		end
	end
endmodule : dual_stage_watchdog

// [rtl/wdt_pulse.sv]
// Stretches a one-cycle request into a pulse of a fixed number of cycles.
// Assumes the same clock for request and output.
`timescale 1ns/10ps
module wdt_pulse
	import wdt_pkg::*;
(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic fire,
	output logic      pulse
);
	logic [7:0] cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt   <= 8'h00;
			pulse <= 1'b0;
		end else if (fire) begin
			cnt   <= pulse_cycles - 8'h01;
			pulse <= 1'b1;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end else begin
			pulse <= 1'b0;
		end
	end
endmodule : wdt_pulse

// [rtl/wdt_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input; output changes when stages two and three agree.
`timescale 1ns/10ps
module wdt_sync (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic din,
	output logic      dout
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1   <= 1'b1;
			s2   <= 1'b1;
			s3   <= 1'b1;
			dout <= 1'b1;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule : wdt_sync

// [tb/carrier_model.sv]
// Carrier stand-in: periodic keep-alive strobes while go is high.
// Assumes hclk from the bench; the strobe line idles high on its pull-up.
`timescale 1ns/10ps
module carrier_model (
	input  wire logic hclk,
	input  wire logic go,
	output logic      keepalive_strobe_n
);
	initial keepalive_strobe_n = 1'b1;
	// Four cycles low, long enough for the input synchroniser
	always begin
		@(posedge hclk);
		if (go) begin
			keepalive_strobe_n <= 1'b0;
			repeat (4) @(posedge hclk);
			keepalive_strobe_n <= 1'b1;
			repeat (96) @(posedge hclk);
		end
	end
endmodule : carrier_model

// [tb/dual_stage_watchdog_asserts.sv]
// Checker: bus and pin relations of the watchdog.
// Assumes 50-cycle action pulses and a zero-wait slave.
`timescale 1ns/10ps
module dual_stage_watchdog_asserts (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        timeout_indicator_out,
	input wire logic        module_reset,
	input wire logic        nmi_irq,
	input wire logic        sys_mgmt_irq,
	input wire logic        sys_control_irq
);
	wire logic rd = hsel && hready && htrans[1] && !hwrite;
	wire logic wr = hsel && hready && htrans[1] && hwrite;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("wait state");
	property p_okay; !hresp; endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_rdata; $changed(hrdata) |-> $past(rd); endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
	property p_rst; $fell(module_reset) |-> $past(module_reset, 50) && !$past(module_reset, 51);
	endproperty
	a_rst: assert property (p_rst) else $error("reset pulse width");
	property p_nmi; $fell(nmi_irq) |-> $past(nmi_irq, 50) && !$past(nmi_irq, 51); endproperty
	a_nmi: assert property (p_nmi) else $error("nmi pulse width");
	property p_smi; $fell(sys_mgmt_irq) |-> $past(sys_mgmt_irq, 50) && !$past(sys_mgmt_irq, 51);
	endproperty
	a_smi: assert property (p_smi) else $error("smi pulse width");
	property p_sci;
		$fell(sys_control_irq) |-> $past(sys_control_irq, 50) && !$past(sys_control_irq, 51);
	endproperty
	a_sci: assert property (p_sci) else $error("sci pulse width");
	// Only software clears the indicator
	property p_ind; $fell(timeout_indicator_out) |-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
	endproperty
	a_ind: assert property (p_ind) else $error("indicator dropped");
endmodule : dual_stage_watchdog_asserts
bind dual_stage_watchdog dual_stage_watchdog_asserts dual_stage_watchdog_asserts_inst (
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
	.timeout_indicator_out, .module_reset, .nmi_irq, .sys_mgmt_irq, .sys_control_irq
);

// [tb/dual_stage_watchdog_tb_top.sv]
// Bench: AHB-Lite register traffic, strobes and action pin checks.
// Assumes the carrier model and the bound checker.
`timescale 1ns/10ps
`define CHK(n, e, s) begin \
	tests_run++; \
	if ((s) !== (e)) begin \
		mismatches++; \
		$display("[FAIL] %s expected %0h seen %0h", n, e, s); \
	end \
end
module dual_stage_watchdog_tb_top;
	import wdt_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, go, hreadyout, hresp;
	logic        timeout_indicator_out, keepalive_strobe_n;
	logic        module_reset, nmi_irq, sys_mgmt_irq, sys_control_irq;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [3:0]  v;
	int          n;
	int          mismatches = 0;
	int          tests_run = 0;
	dual_stage_watchdog dual_stage_watchdog_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.keepalive_strobe_n, .timeout_indicator_out, .module_reset, .nmi_irq,
		.sys_mgmt_irq, .sys_control_irq);
	carrier_model carrier_model_inst (.hclk, .go, .keepalive_strobe_n);
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		{hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		d = hrdata;
	endtask : xfer
	task automatic wait_act(input int lim);
		n = 0;
		v = 4'h0;
		while (v === 4'h0 && n < lim) begin
			@(negedge hclk);
			v = {sys_control_irq, sys_mgmt_irq, nmi_irq, module_reset};
			n++;
		end
	endtask : wait_act
	task automatic setup(input int p1, input int p2, input logic [31:0] c);
		xfer(1'b1, stage1_addr, 32'(p1));
		xfer(1'b1, stage2_addr, 32'(p2));
		xfer(1'b1, ctrl_addr, c);
	endtask : setup
	task automatic stop;
		xfer(1'b1, ctrl_addr, 32'h0);
		xfer(1'b1, status_addr, 32'h4);
		repeat (60) @(negedge hclk);
	endtask : stop
	task automatic t_regs;
		xfer(1'b0, ctrl_addr, 32'h0);
		`CHK("ctrl", 32'h0, d)
		xfer(1'b0, stage2_addr, 32'h0);
		`CHK("period2", 32'h02FA_F080, d)
		xfer(1'b1, stage1_addr, 32'h0000_0123);
		xfer(1'b0, stage1_addr, 32'h0);
		`CHK("period1", 32'h0000_0123, d)
		xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
		xfer(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 32'h0, d)
	endtask : t_regs
	task automatic t_actions;
		for (int i = 1; i <= 4; i++) begin
			setup(40, 500, {21'h0, act_none, 1'b0, 3'(i), 4'h3});
			wait_act(200);
			`CHK("action pin", 4'(1 << (i - 1)), v)
			repeat (3) @(negedge hclk);
			`CHK("indicator", 1'b1, timeout_indicator_out)
			xfer(1'b0, status_addr, 32'h0);
			`CHK("flag", 1'b1, d[stat_tout_bit])
			`CHK("stage done", 2'h3, d[stat_stage_lsb +: 2])
			stop();
		end
	endtask : t_actions
	task automatic t_skip_delay;
		setup(40, 20, {21'h0, act_sci, 1'b0, act_none, 4'h1});
		wait_act(300);
		`CHK("skip pin", 4'h8, v)
		`CHK("skip time", 1'b1, n < 40)
		`CHK("indicator off", 1'b0, timeout_indicator_out)
		stop();
		setup(100, 20, {21'h0, act_sci, 1'b0, act_delay, 4'h3});
		wait_act(300);
		`CHK("delay pin", 4'h8, v)
		`CHK("delay time", 1'b1, n >= 118 && n < 140)
		stop();
	endtask : t_skip_delay
	task automatic t_service;
		setup(300, 80, {21'h0, act_sci, 1'b0, act_nmi, 4'h3});
		go <= 1'b1;
		wait_act(1000);
		`CHK("strobed", 4'h0, v)
		go <= 1'b0;
		repeat (3) begin
			xfer(1'b1, trigger_addr, 32'h1);
			wait_act(250);
			`CHK("triggered", 4'h0, v)
		end
		wait_act(100);
		`CHK("stage one", 4'h2, v)
		repeat (60) @(negedge hclk);
		wait_act(100);
		`CHK("stage two", 4'h8, v)
		stop();
	endtask : t_service
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, go, htrans, haddr, hwdata} = '0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_actions();
		t_skip_delay();
		t_service();
		test_done();
	end
	// Whole run is near 2800 cycles
	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		test_done();
	end
endmodule : dual_stage_watchdog_tb_top
